/* File: rtl/awdt_pkg.sv */
// ****************************************************************
// watchdog constants
// ****************************************************************
package awdt_pkg;

    // ************************************************************
    // register byte offsets (compared against {paddr, 2'b00})
    // ************************************************************
    localparam logic [11:0] AWDT_OFF_RELOAD = 12'h000;
    localparam logic [11:0] AWDT_OFF_COUNT = 12'h004;
    localparam logic [11:0] AWDT_OFF_CONTROL = 12'h008;
    localparam logic [11:0] AWDT_OFF_INT_CLEAR = 12'h00C;
    localparam logic [11:0] AWDT_OFF_RAW_STATUS = 12'h010;
    localparam logic [11:0] AWDT_OFF_MASKED_STATUS = 12'h014;
    localparam logic [11:0] AWDT_OFF_WRITE_PROTECT = 12'hC00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AWDT_CTRL_COUNT_INTERRUPT_ENABLE_BIT = 0;
    localparam int AWDT_CTRL_RESET_OUTPUT_ENABLE_BIT = 1;
    localparam int AWDT_STATUS_BIT = 0;

    // ************************************************************
    // reset values and key
    // ************************************************************
    localparam logic [31:0] AWDT_RELOAD_RST = 32'hFFFFFFFF;
    localparam logic [31:0] AWDT_COUNT_RST = 32'hFFFFFFFF;
    localparam logic [1:0] AWDT_CONTROL_RST = 2'h0;
    localparam logic AWDT_LOCKED_RST = 1'h0;
    localparam logic [31:0] AWDT_UNLOCK_KEY = 32'h1ACCE551;
    localparam logic [31:0] AWDT_LOCK_READ_OPEN = 32'h00000000;
    localparam logic [31:0] AWDT_LOCK_READ_SHUT = 32'h00000001;
    localparam logic [31:0] AWDT_READ_ZERO = 32'h00000000;

    // ************************************************************
    // counter state machine
    // ************************************************************
    typedef enum logic [2:0] {
        AWDT_ST_STOP = 3'b001,
        AWDT_ST_RUN = 3'b010,
        AWDT_ST_HALT = 3'b100
    } awdt_state_t;

endpackage

/* File: rtl/awdt_apb_decode.sv */
`timescale 1ns/1ps
// ****************************************************************
// apb address decode and write strobes
// ****************************************************************
module awdt_apb_decode
    import awdt_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // apb request
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:2] i_paddr,
    // protection state
    input wire logic i_locked,
    // decoded strobes
    output logic o_wr_reload,
    output logic o_wr_control,
    output logic o_wr_int_clear,
    output logic o_wr_protect,
    output logic o_rd_setup,
    output logic [11:0] o_byte_addr
);

    logic wr_access;
    logic wr_open;

    assign o_byte_addr = {i_paddr, 2'b00};
    // write in access phase, read captured in setup phase
    assign wr_access = i_psel & i_penable & i_pwrite;
    assign o_rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign wr_open = wr_access & ~i_locked;

    // per register strobes; unmapped writes produce none
    assign o_wr_reload = wr_open & (o_byte_addr == AWDT_OFF_RELOAD);
    assign o_wr_control = wr_open & (o_byte_addr == AWDT_OFF_CONTROL);
    assign o_wr_int_clear = wr_open & (o_byte_addr == AWDT_OFF_INT_CLEAR);
    // protect register stays writable while locked
    assign o_wr_protect = wr_access & (o_byte_addr == AWDT_OFF_WRITE_PROTECT);

endmodule

/* File: rtl/awdt_lock.sv */
`timescale 1ns/1ps
// ****************************************************************
// write protect key holder
// ****************************************************************
module awdt_lock
    import awdt_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // key write
    input wire logic i_wr_protect,
    input wire logic [31:0] i_pwdata,
    // lock state
    output logic o_locked
);

    // key opens, any other value shuts
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_locked <= AWDT_LOCKED_RST;
        end else if (i_wr_protect) begin
            o_locked <= (i_pwdata != AWDT_UNLOCK_KEY);
        end
    end

endmodule

/* File: rtl/apb_watchdog_timer.sv */
`timescale 1ns/1ps
// Overview of operation
// - reload write restarts counter immediately
// - reload zero raises interrupt on the first enabled count edge
// - current count readable, read only
// - control bit one gates timeout reset
// - control bit zero runs counter, allows interrupt
// - enable rising edge reloads before counting
// - any clear write drops interrupt unless a new zero hits that edge, reloads
// - raw status set when counter hits zero
// - masked status is raw and enable
// - key unlocks writes, other value locks
// - protect read returns lock state
// - apb slave, address bits eleven to two
// - interrupt output active high
// - timeout reset output active high
// - counter domain reset active low
// - decrement only on enabled count edges
// - at zero interrupt and reload on the same edge, or halt if reset enabled and interrupt pending
// - clear drops interrupt without count edge
module apb_watchdog_timer
    import awdt_pkg::*;
(
    // clock and bus reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:2] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    // count clock qualifier and counter reset
    input wire logic i_count_clock_enable,
    input wire logic i_count_domain_reset_n,
    // timeout outputs
    output logic o_timeout_irq,
    output logic o_timeout_reset_out
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic wr_reload;
    logic wr_control;
    logic wr_int_clear;
    logic wr_protect;
    logic rd_setup;
    logic [11:0] byte_addr;
    logic locked;

    logic [31:0] reload_value;
    logic count_interrupt_enable;
    logic reset_output_enable;

    awdt_state_t cnt_state;
    awdt_state_t next_cnt_state;
    logic [31:0] current_count;
    logic reload_pending;
    logic raw_status_bit;
    logic masked_status_bit;
    logic reset_hold;

    logic tick;
    logic running;
    logic zero_hit;
    logic halt_hit;
    logic [31:0] next_prdata;

    // ************************************************************
    // bus decode and write protection
    // ************************************************************

    awdt_apb_decode u_decode (
        .i_clk_sys(i_clk_sys),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_locked(locked),
        .o_wr_reload(wr_reload),
        .o_wr_control(wr_control),
        .o_wr_int_clear(wr_int_clear),
        .o_wr_protect(wr_protect),
        .o_rd_setup(rd_setup),
        .o_byte_addr(byte_addr)
    );

    awdt_lock u_lock (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_protect(wr_protect),
        .i_pwdata(i_pwdata),
        .o_locked(locked)
    );

    // ************************************************************
    // software registers (bus reset)
    // ************************************************************

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            reload_value <= AWDT_RELOAD_RST;
        end else if (wr_reload) begin
            reload_value <= i_pwdata;
        end
    end

    // control bits, upper bits not stored
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            count_interrupt_enable <= AWDT_CONTROL_RST[AWDT_CTRL_COUNT_INTERRUPT_ENABLE_BIT];
            reset_output_enable <= AWDT_CONTROL_RST[AWDT_CTRL_RESET_OUTPUT_ENABLE_BIT];
        end else if (wr_control) begin
            count_interrupt_enable <= i_pwdata[AWDT_CTRL_COUNT_INTERRUPT_ENABLE_BIT];
            reset_output_enable <= i_pwdata[AWDT_CTRL_RESET_OUTPUT_ENABLE_BIT];
        end
    end

    // ************************************************************
    // counter events
    // ************************************************************

    assign tick = i_count_clock_enable;
    assign running = (cnt_state == AWDT_ST_RUN) & count_interrupt_enable;

    // zero reload fires on its first edge
    // zero reached on an enabled edge
    assign zero_hit = running & tick
        & (reload_pending ? (reload_value == AWDT_READ_ZERO)
                          : (current_count == AWDT_READ_ZERO));

    // second zero with interrupt still pending
    assign halt_hit = zero_hit & raw_status_bit & reset_output_enable;

    // ************************************************************
    // counter state machine (counter reset)
    // ************************************************************

    // next state
    always_comb begin
        next_cnt_state = cnt_state;
        unique case (cnt_state)
            AWDT_ST_STOP: begin
                if (count_interrupt_enable) begin
                    next_cnt_state = AWDT_ST_RUN;
                end
            end
            AWDT_ST_RUN: begin
                if (!count_interrupt_enable) begin
                    next_cnt_state = AWDT_ST_STOP;
                end else if (halt_hit) begin
                    next_cnt_state = AWDT_ST_HALT;
                end
            end
            AWDT_ST_HALT: begin
                next_cnt_state = AWDT_ST_HALT; // held until counter reset
            end
            default: begin
                next_cnt_state = AWDT_ST_STOP;
            end
        endcase
    end

    // state register on active low counter reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            cnt_state <= AWDT_ST_STOP;
        end else begin
            cnt_state <= next_cnt_state;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            reload_pending <= 1'b0;
        end else if (cnt_state == AWDT_ST_STOP && count_interrupt_enable) begin
            reload_pending <= 1'b1;
        end else if (wr_reload || wr_int_clear || (running && tick)) begin
            reload_pending <= 1'b0;
        end
    end

    // ************************************************************
    // down counter
    // ************************************************************

    // counter value, bus reloads take priority over counting
    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            current_count <= AWDT_COUNT_RST;
        end else if (wr_reload) begin
            current_count <= i_pwdata;
        end else if (wr_int_clear) begin
            current_count <= reload_value;
        end else if (running && tick && !halt_hit) begin
            if (reload_pending || zero_hit) begin
                current_count <= reload_value;
            end else begin
                current_count <= current_count - 32'h00000001;
            end
        end
    end

    // ************************************************************
    // interrupt and timeout reset
    // ************************************************************

    // raw flag, a new zero wins over a clear
    // clear takes effect on the bus edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            raw_status_bit <= 1'b0;
        end else begin
            raw_status_bit <= zero_hit | (raw_status_bit & ~wr_int_clear);
        end
    end

    // masked status shared with interrupt pin
    assign masked_status_bit = raw_status_bit & count_interrupt_enable;
    assign o_timeout_irq = masked_status_bit;

    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            reset_hold <= 1'b0;
        end else if (halt_hit) begin
            reset_hold <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_count_domain_reset_n) begin
            o_timeout_reset_out <= 1'b0;
        end else begin
            o_timeout_reset_out <= (reset_hold | halt_hit) & reset_output_enable;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************

    // read mux
    always_comb begin
        next_prdata = AWDT_READ_ZERO;
        unique case (byte_addr)
            AWDT_OFF_RELOAD: begin
                next_prdata = reload_value;
            end
            AWDT_OFF_COUNT: begin
                next_prdata = current_count;
            end
            AWDT_OFF_CONTROL: begin
                next_prdata[AWDT_CTRL_COUNT_INTERRUPT_ENABLE_BIT] = count_interrupt_enable;
                next_prdata[AWDT_CTRL_RESET_OUTPUT_ENABLE_BIT] = reset_output_enable;
            end
            AWDT_OFF_RAW_STATUS: begin
                next_prdata[AWDT_STATUS_BIT] = raw_status_bit;
            end
            AWDT_OFF_MASKED_STATUS: begin
                next_prdata[AWDT_STATUS_BIT] = masked_status_bit;
            end
            AWDT_OFF_WRITE_PROTECT: begin
                next_prdata = locked ? AWDT_LOCK_READ_SHUT : AWDT_LOCK_READ_OPEN;
            end
            default: begin
                // clear location and gaps read zero
                next_prdata = AWDT_READ_ZERO;
            end
        endcase
    end

    // read data registered at setup, valid in access phase
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_prdata <= AWDT_READ_ZERO;
        end else if (rd_setup) begin
            o_prdata <= next_prdata;
        end
    end

endmodule

/* File: tb/awdt_checker.sv */
`timescale 1ns/1ps
// ****************************************
// port checker for the watchdog
// ****************************************
module awdt_checker (
    // clock and resets
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_count_domain_reset_n,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:2] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    // count qualifier and outputs
    input wire logic i_count_clock_enable,
    input wire logic o_timeout_irq,
    input wire logic o_timeout_reset_out
);
    logic wr;
    logic rs;
    logic clr;
    logic lk;
    logic [1:0] ctl;
    // decoded bus phases
    assign wr = i_psel && i_penable && i_pwrite;
    assign rs = i_psel && !i_penable && !i_pwrite;
    assign clr = wr && !lk && i_paddr == 10'h003;
    // shadow of lock state and control bits
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            lk <= 1'b0;
            ctl <= 2'h0;
        end else if (wr) begin
            if (i_paddr == 10'h300) lk <= (i_pwdata != 32'h1ACCE551);
            if (!lk && i_paddr == 10'h002) ctl <= i_pwdata[1:0];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_lock_read;
        rs && i_paddr == 10'h300 |=> o_prdata == {31'h0, lk};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");
    property p_ctrl_read;
        rs && i_paddr == 10'h002 |=> o_prdata == {30'h0, ctl};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_rsvd_read;
        rs && (i_paddr == 10'h003 || (i_paddr > 10'h005 && i_paddr != 10'h300))
            |=> o_prdata == 32'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");
    property p_mis_read;
        rs && i_paddr == 10'h005 |=> o_prdata == {31'h0, $past(o_timeout_irq)};
    endproperty
    a_mis_read: assert property (p_mis_read) else $error("masked status wrong");
    property p_irq_masked;
        o_timeout_irq |-> ctl[0];
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");
    property p_irq_clear;
        clr |=> !o_timeout_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept after clear");
    property p_irq_fall;
        $fell(o_timeout_irq) |-> $past(clr) || !ctl[0] || !$past(i_count_domain_reset_n);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
    property p_rst_gate;
        $rose(o_timeout_reset_out) |-> ctl[1] && $past(o_timeout_irq);
    endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("reset out without cause");
    property p_rst_hold;
        o_timeout_reset_out && i_count_domain_reset_n ##1 ctl[1] |-> o_timeout_reset_out;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset out dropped");
    property p_cnt_reset;
        !i_count_domain_reset_n |=> !o_timeout_irq && !o_timeout_reset_out;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("counter reset ignored");
    c_irq: cover property ($rose(o_timeout_irq));
    c_rst: cover property ($rose(o_timeout_reset_out));
    c_clr: cover property (clr && o_timeout_irq && i_count_clock_enable);
endmodule

bind apb_watchdog_timer awdt_checker i_awdt_checker (.i_clk_sys, .i_rst_n,
    .i_count_domain_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .i_count_clock_enable, .o_timeout_irq, .o_timeout_reset_out);

/* File: tb/awdt_apb_bridge.sv */
`timescale 1ns/1ps
// ****************************************
// apb bridge model
// ****************************************
module awdt_apb_bridge (
    // clock
    input wire logic i_clk_sys,
    // apb request
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:2] o_paddr,
    output logic [31:0] o_pwdata,
    // apb answer
    input wire logic [31:0] i_prdata
);
    // idle bus at time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 10'h000;
        o_pwdata = 32'h00000000;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_pwrite <= 1'b1;
        o_paddr <= a[11:2];
        o_pwdata <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        @(posedge i_clk_sys);
        // released lines show the inverse of the last value
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a[11:2];
        o_pwdata <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_pwrite <= 1'b0;
        o_paddr <= a[11:2];
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        @(posedge i_clk_sys);
        d = i_prdata;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a[11:2];
    endtask
endmodule

/* File: tb/apb_watchdog_timer_tb.sv */
`timescale 1ns/1ps
module apb_watchdog_timer_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_count_domain_reset_n = 1'b0;
    logic i_count_clock_enable = 1'b1;
    logic i_psel, i_penable, i_pwrite, o_timeout_irq, o_timeout_reset_out;
    logic [11:2] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    int bad_count = 0;
    int cmp_count = 0;
    logic [11:0] ra [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
        12'h018, 12'hBFC, 12'hC00, 12'hFFC};
    logic [31:0] re [10] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    // 40 mhz clock
    always #12.5 i_clk_sys = ~i_clk_sys;
    apb_watchdog_timer i_apb_watchdog_timer (.i_clk_sys, .i_rst_n, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .i_count_clock_enable,
        .i_count_domain_reset_n, .o_timeout_irq, .o_timeout_reset_out);
    awdt_apb_bridge i_awdt_apb_bridge (.i_clk_sys, .o_psel(i_psel), .o_penable(i_penable),
        .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .i_prdata(o_prdata));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_awdt_apb_bridge.rd(a, d);
        chk(d, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_awdt_apb_bridge.wr(a, d);
    endtask
    // count falling edges until irq or reset out rises
    task automatic wait_hi(input logic rst, input int exp);
        int m;
        m = 0;
        do begin
            @(negedge i_clk_sys);
            m++;
        end while ((rst ? o_timeout_reset_out : o_timeout_irq) !== 1'b1 && m < 40);
        chk(m, exp);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        i_count_domain_reset_n <= 1'b1;
        for (int k = 0; k < 10; k++) rd_chk(ra[k], re[k]);
        wr(12'hC00, 32'h00001234);
        rd_chk(12'hC00, 32'h00000001);
        wr(12'h000, 32'h00000005);
        wr(12'h008, 32'h00000001);
        rd_chk(12'h000, 32'hFFFFFFFF);
        rd_chk(12'h008, 32'h00000000);
        wr(12'hC00, 32'h1ACCE551);
        rd_chk(12'hC00, 32'h00000000);
        wr(12'h004, 32'h00000000);
        rd_chk(12'h004, 32'hFFFFFFFF);
        wr(12'h008, 32'hFFFFFFFC);
        rd_chk(12'h008, 32'h00000000);
        wr(12'h000, 32'h00000005);
        wr(12'h008, 32'h00000001);
        // state runs one edge after the enable write, load on the next, then 6 edges
        wait_hi(1'b0, 9);
        wr(12'h00C, 32'hA5A5A5A5);
        @(negedge i_clk_sys);
        chk(o_timeout_irq, 1'b0);
        wait_hi(1'b0, 6);
        repeat (14) @(negedge i_clk_sys);
        chk(o_timeout_reset_out, 1'b0);
        rd_chk(12'h014, 32'h00000001);
        wr(12'h008, 32'h00000000);
        @(negedge i_clk_sys);
        chk(o_timeout_irq, 1'b0);
        rd_chk(12'h010, 32'h00000001);
        rd_chk(12'h014, 32'h00000000);
        wr(12'h00C, 32'h00000000);
        wr(12'h000, 32'h00000000);
        wr(12'h008, 32'h00000001);
        // zero reload fires on the load edge, two edges after the enable write
        wait_hi(1'b0, 3);
        wr(12'h008, 32'h00000000);
        wr(12'h00C, 32'h00000000);
        wr(12'h000, 32'h00000005);
        wr(12'h008, 32'h00000003);
        repeat (3) @(posedge i_clk_sys);
        wr(12'h000, 32'h00000005);
        wait_hi(1'b0, 7);
        // stall the count qualifier for four edges
        @(posedge i_clk_sys);
        i_count_clock_enable <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_count_clock_enable <= 1'b1;
        wait_hi(1'b1, 6);
        rd_chk(12'h004, 32'h00000000);
        chk(o_timeout_reset_out, 1'b1);
        @(posedge i_clk_sys);
        i_count_domain_reset_n <= 1'b0;
        @(posedge i_clk_sys);
        i_count_domain_reset_n <= 1'b1;
        @(negedge i_clk_sys);
        chk({o_timeout_irq, o_timeout_reset_out}, 2'b00);
        rd_chk(12'h004, 32'hFFFFFFFF);
        final_report;
    end
    // watchdog: tests need well under 1000 cycles, cut off at 3000
    initial begin
        #75000;
        bad_count++;
        final_report;
    end
endmodule
